// *** verilog/fdr_pkg.sv ***
// constants for the divider-enable, half-integer and ramp-step control block
// assumes one 200 MHz clock and a simple word-wide register write port
package fdr_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int XTAL_W = 16;
    localparam logic [7:0] ADDR_DIV_RAMP = 8'h03;
    localparam logic [7:0] ADDR_XTAL_BUF = 8'h04;
    localparam logic [31:0] DIV_RAMP_RESET = 32'h0000_0000;
    localparam logic [31:0] DIV_RAMP_MASK = 32'h000F_0FFF;
    localparam logic [15:0] XTAL_BUF_RESET = 16'h0000;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int NUM_OUT = 4;
    localparam int MANT_LSB = 0;
    localparam int MANT_W = 4;
    localparam int EXP_LSB = 4;
    localparam int EXP_W = 4;
    localparam int HALF_SEL_LSB = 8;
    localparam int DIV_EN_LSB = 16;

    // ------------------------------------------------------------
    // dividers and ramp
    // ------------------------------------------------------------
    localparam int INT_DIV_W = 8;
    localparam int FRAC_W = 32;
    localparam logic [7:0] HALF_SHORT_CNT = 8'h04;
    localparam logic [7:0] HALF_LONG_CNT = 8'h05;
    localparam logic [7:0] MIN_DIV_CNT = 8'h01;

    typedef enum logic [0:0] {
        FDR_HOLD = 1'b0,
        FDR_RAMP = 1'b1
    } fdr_ramp_e;
endpackage

// *** verilog/fdr_out_div.sv ***
// one output divider: emits a one-cycle tick per divided period
// assumes the integer value and mode bit are static or change rarely
`timescale 1ns/1ps
module fdr_out_div (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // control
    input wire logic en_i,
    input wire logic half_sel_i,
    input wire logic [7:0] int_div_i,
    // output
    output logic tick_o
);
    logic [7:0] cnt_reg;
    logic long_reg;
    logic [7:0] period;

    // ------------------------------------------------------------
    // period select
    // ------------------------------------------------------------
    // 4.5 made as alternating 4 and 5 cycle periods, one clock only
    always_comb begin
        if (half_sel_i) begin
            period = long_reg ? fdr_pkg::HALF_LONG_CNT : fdr_pkg::HALF_SHORT_CNT;
        end else if (int_div_i == 8'h00) begin
            period = fdr_pkg::MIN_DIV_CNT;
        end else begin
            period = int_div_i;
        end
    end

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg <= 8'h00;
            long_reg <= 1'b0;
            tick_o <= 1'b0;
        end else if (!en_i) begin
            cnt_reg <= 8'h00;
            long_reg <= 1'b0;
            tick_o <= 1'b0;
        end else if (cnt_reg >= period - 8'h01) begin
            // >= so a smaller new value never strands the counter
            cnt_reg <= 8'h00;
            long_reg <= ~long_reg;
            tick_o <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
            tick_o <= 1'b0;
        end
    end
endmodule

// *** verilog/fdr_div_ctrl.sv ***
// divider-enable, half-integer mode and fractional feedback ramp control
// assumes register writes arrive already decoded from the serial port
// assumes the feedback target strobe is a single-cycle pulse
`timescale 1ns/1ps
module fdr_div_ctrl (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    output logic [31:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // feedback divider target
    input wire logic frac_wr_i,
    input wire logic [31:0] frac_target_i,
    output logic [31:0] frac_div_o,
    output logic ramp_busy_o,
    // output dividers
    input wire logic [31:0] output_int_div_value_i,
    output logic [3:0] out_tick_o,
    output logic [3:0] div_en_o,
    output logic [3:0] half_integer_div_sel_o,
    // crystal and buffer settings, passed to analog
    output logic [15:0] xtal_buf_cfg_o
);
    logic [31:0] div_ramp_reg;
    logic [15:0] xtal_buf_reg;
    logic [31:0] target_reg;
    logic [31:0] work_reg;
    fdr_pkg::fdr_ramp_e state_reg;
    logic [3:0] mant;
    logic [3:0] expo;
    logic [31:0] step;
    logic [31:0] gap;
    logic mant_zero;
    logic ramp_last;
    logic ramp_up;
    logic wr_ctrl;
    logic wr_xtal;
    logic [31:0] rd_word;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    // one compare per register, each used only by its own write process
    assign wr_ctrl = reg_wr_i && (reg_addr_i == fdr_pkg::ADDR_DIV_RAMP);
    assign wr_xtal = reg_wr_i && (reg_addr_i == fdr_pkg::ADDR_XTAL_BUF);

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_ramp_reg <= fdr_pkg::DIV_RAMP_RESET;
        end else if (wr_ctrl) begin
            // unused bits forced to zero so they read back as zero
            div_ramp_reg <= reg_wdata_i & fdr_pkg::DIV_RAMP_MASK;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            xtal_buf_reg <= fdr_pkg::XTAL_BUF_RESET;
        end else if (wr_xtal) begin
            // passed to the analog side untouched
            xtal_buf_reg <= reg_wdata_i[15:0];
        end
    end

    // ------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------
    // unmapped addresses read as zero
    always_comb begin
        case (reg_addr_i)
            fdr_pkg::ADDR_DIV_RAMP: rd_word = div_ramp_reg;
            fdr_pkg::ADDR_XTAL_BUF: rd_word = {16'h0000, xtal_buf_reg};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // read data held until the next read, so a slow host can take it late
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rd_word;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
        end
    end

    // ------------------------------------------------------------
    // register fields
    // ------------------------------------------------------------
    assign xtal_buf_cfg_o = xtal_buf_reg;
    assign div_en_o = div_ramp_reg[fdr_pkg::DIV_EN_LSB +: fdr_pkg::NUM_OUT];
    assign half_integer_div_sel_o = div_ramp_reg[fdr_pkg::HALF_SEL_LSB +: fdr_pkg::NUM_OUT];

    // ------------------------------------------------------------
    // output dividers
    // ------------------------------------------------------------
    // one divider per output, all on the same clock
    genvar g;
    generate
        for (g = 0; g < fdr_pkg::NUM_OUT; g = g + 1) begin : gen_div
            logic [7:0] int_div;
            // still routed in half mode; the divider itself ignores it there
            assign int_div = output_int_div_value_i[g*fdr_pkg::INT_DIV_W +: fdr_pkg::INT_DIV_W];
            fdr_out_div u_div (
                .clk_i(clk_i),
                .rst_n_i(rst_n_i),
                .en_i(div_en_o[g]),
                .half_sel_i(half_integer_div_sel_o[g]),
                .int_div_i(int_div),
                .tick_o(out_tick_o[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // ramp step
    // ------------------------------------------------------------
    assign mant = div_ramp_reg[fdr_pkg::MANT_LSB +: fdr_pkg::MANT_W];
    assign expo = div_ramp_reg[fdr_pkg::EXP_LSB +: fdr_pkg::EXP_W];
    // widest step is 15 << 15, well inside 32 bits
    assign step = {28'h000_0000, mant} << expo;
    // distance still to go, without sign
    assign gap = (work_reg > target_reg) ? (work_reg - target_reg) : (target_reg - work_reg);
    assign mant_zero = (mant == 4'h0);
    // landing judged on the gap, so a coarse step never wraps past the target
    assign ramp_last = mant_zero || (gap <= step);
    assign ramp_up = (work_reg < target_reg);

    // ------------------------------------------------------------
    // ramp state
    // ------------------------------------------------------------
    // target latched on every write, even while a ramp runs
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            target_reg <= 32'h0000_0000;
        end else if (frac_wr_i) begin
            target_reg <= frac_target_i;
        end
    end

    // step size is read live, so a field change mid-ramp takes effect on the next step
    // a write mid-ramp keeps the working value and turns toward the new target
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= fdr_pkg::FDR_HOLD;
        end else if (frac_wr_i) begin
            if (mant_zero) begin
                state_reg <= fdr_pkg::FDR_HOLD;
            end else begin
                state_reg <= fdr_pkg::FDR_RAMP;
            end
        end else begin
            case (state_reg)
                fdr_pkg::FDR_RAMP: begin
                    if (ramp_last) begin
                        state_reg <= fdr_pkg::FDR_HOLD;
                    end
                end
                fdr_pkg::FDR_HOLD: begin
                    state_reg <= fdr_pkg::FDR_HOLD;
                end
                default: begin
                    state_reg <= fdr_pkg::FDR_HOLD;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // working feedback value
    // ------------------------------------------------------------
    // holds between ramps; only a new target or a ramp step moves it
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            work_reg <= 32'h0000_0000;
        end else if (frac_wr_i) begin
            if (mant_zero) begin
                work_reg <= frac_target_i;
            end
        end else if (state_reg == fdr_pkg::FDR_RAMP) begin
            if (ramp_last) begin
                work_reg <= target_reg;
            end else if (ramp_up) begin
                work_reg <= work_reg + step;
            end else begin
                work_reg <= work_reg - step;
            end
        end
    end

    // ------------------------------------------------------------
    // ramp status
    // ------------------------------------------------------------
    // busy comes straight from the state register, no extra cycle of lag
    assign frac_div_o = work_reg;
    assign ramp_busy_o = (state_reg == fdr_pkg::FDR_RAMP);
endmodule

// *** verif/fdr_div_ctrl_assertions.sv ***
// checker: half mode and feedback ramp at the top ports
// assumes ctrl register sits at the package address
`timescale 1ns/1ps
module fdr_div_ctrl_assertions (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic frac_wr_i,
    input wire logic [31:0] frac_target_i,
    input wire logic [31:0] frac_div_o,
    input wire logic ramp_busy_o,
    input wire logic [3:0] out_tick_o,
    input wire logic [3:0] div_en_o,
    input wire logic [3:0] half_integer_div_sel_o
);
    logic [7:0] ctl_reg;
    logic [31:0] tgt_reg;
    logic [31:0] step;
    assign step = {28'h0, ctl_reg[3:0]} << ctl_reg[7:4];
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            ctl_reg <= 8'h00;
        else if (reg_wr_i && reg_addr_i == fdr_pkg::ADDR_DIV_RAMP)
            ctl_reg <= reg_wdata_i[7:0];
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            tgt_reg <= 32'h0;
        else if (frac_wr_i)
            tgt_reg <= frac_target_i;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // tick period of four or five
    sequence s_gap45;
        (!out_tick_o[0]) [*3] ##1 (out_tick_o[0] or (!out_tick_o[0] ##1 out_tick_o[0]));
    endsequence
    chk_half_bits: assert property (reg_wr_i && reg_addr_i == fdr_pkg::ADDR_DIV_RAMP |=>
        half_integer_div_sel_o == $past(reg_wdata_i[11:8])) else $error("half bits");
    chk_half_period: assert property (disable iff (!rst_n_i || !div_en_o[0] ||
        !half_integer_div_sel_o[0]) out_tick_o[0] && half_integer_div_sel_o[0] |=>
        s_gap45) else $error("half period");
    chk_ramp_start: assert property (frac_wr_i && ctl_reg[3:0] != 4'h0 &&
        frac_target_i != frac_div_o |=> ramp_busy_o) else $error("no ramp");
    chk_ramp_step: assert property (ramp_busy_o && !frac_wr_i |=> frac_div_o == tgt_reg ||
        frac_div_o == $past(frac_div_o) + $past(step) ||
        frac_div_o == $past(frac_div_o) - $past(step)) else $error("bad step");
    chk_ramp_land: assert property (ramp_busy_o ##1 !ramp_busy_o |->
        frac_div_o == tgt_reg) else $error("missed target");
    chk_ramp_hold: assert property (!ramp_busy_o && !frac_wr_i |=>
        $stable(frac_div_o)) else $error("value drifts");
    chk_ramp_now: assert property (frac_wr_i && ctl_reg[3:0] == 4'h0 |=>
        frac_div_o == $past(frac_target_i) && !ramp_busy_o) else $error("not at once");
endmodule
bind fdr_div_ctrl fdr_div_ctrl_assertions fdr_div_ctrl_assertions_inst (.clk_i, .rst_n_i,
    .reg_wr_i, .reg_addr_i, .reg_wdata_i, .frac_wr_i, .frac_target_i, .frac_div_o,
    .ramp_busy_o, .out_tick_o, .div_en_o, .half_integer_div_sel_o);

// *** verif/fdr_host_model.sv ***
// host software: register and feedback target writes
// assumes strobes are sampled on the rising edge
`timescale 1ns/1ps
module fdr_host_model (
    input wire logic clk_i,
    input wire logic [31:0] rdata_i,
    output logic wr_o,
    output logic rd_o,
    output logic [7:0] addr_o,
    output logic [31:0] wdata_o,
    output logic frac_wr_o,
    output logic [31:0] frac_o
);
    initial {wr_o, rd_o, frac_wr_o, addr_o, wdata_o, frac_o} = '0;
    // released lines show inverted data, not the last value
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge clk_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge clk_i);
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(negedge clk_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge clk_i);
        rd_o = 1'b0;
        addr_o = ~a;
        d = rdata_i;
    endtask
    task automatic frac(input logic [31:0] t);
        @(negedge clk_i);
        frac_o = t;
        frac_wr_o = 1'b1;
        @(negedge clk_i);
        frac_wr_o = 1'b0;
        frac_o = ~t;
    endtask
endmodule

// *** verif/tb.sv ***
// testbench: registers, output dividers and feedback ramp
// assumes the host model drives the register port
`timescale 1ns/1ps
module tb;
`define CMP(n, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
    $display("unexpected %s exp %0h got %0h", n, e, g); end end
    localparam logic [7:0] CA = fdr_pkg::ADDR_DIV_RAMP;
    localparam logic [7:0] XA = fdr_pkg::ADDR_XTAL_BUF;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic reg_wr_i, reg_rd_i, frac_wr_i, ramp_busy_o, reg_rvalid_o;
    logic [7:0] reg_addr_i;
    logic [31:0] reg_wdata_i, reg_rdata_o, frac_target_i, frac_div_o, d, c;
    logic [31:0] output_int_div_value_i = 32'h0;
    logic [3:0] out_tick_o, div_en_o, half_integer_div_sel_o, m, e;
    logic [15:0] xtal_buf_cfg_o;
    int failures = 0;
    int samples_checked = 0;
    int seed = 21;
    int cyc = 0;
    int n, p;
    realtime t0;
    always #2.5 clk_i = ~clk_i;
    fdr_div_ctrl fdr_div_ctrl_inst (.clk_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
        .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .frac_wr_i, .frac_target_i, .frac_div_o,
        .ramp_busy_o, .output_int_div_value_i, .out_tick_o, .div_en_o,
        .half_integer_div_sel_o, .xtal_buf_cfg_o);
    fdr_host_model host (.clk_i, .rdata_i(reg_rdata_o), .wr_o(reg_wr_i), .rd_o(reg_rd_i),
        .addr_o(reg_addr_i), .wdata_o(reg_wdata_i), .frac_wr_o(frac_wr_i),
        .frac_o(frac_target_i));
    task automatic give_verdict();
        $display("checked %0d failed %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 40000) begin
            failures++;
            give_verdict();
        end
    end
    task automatic period(output int q);
        @(posedge out_tick_o[0]);
        t0 = $realtime;
        @(posedge out_tick_o[0]);
        q = int'(($realtime - t0) / 5.0);
    endtask
    function automatic int ramp_len(logic [31:0] a, logic [31:0] b, logic [3:0] mt,
        logic [3:0] ex);
        logic [31:0] gap;
        logic [31:0] st;
        gap = (b > a) ? b - a : a - b;
        st = {28'h0, mt} << ex;
        return (mt == 4'h0) ? 1 : int'((gap + st - 32'h1) / st);
    endfunction
    initial begin
        repeat (20) @(negedge clk_i);
        rst_n_i = 1'b1;
        host.rd(CA, d);
        `CMP("ctrl reset", fdr_pkg::DIV_RAMP_RESET, d)
        host.wr(CA, 32'hFFFF_FFFF);
        host.rd(CA, d);
        `CMP("ctrl mask", fdr_pkg::DIV_RAMP_MASK, d)
        `CMP("read valid", 1'b1, reg_rvalid_o)
        `CMP("div enables", 4'hF, div_en_o)
        c = $random(seed);
        host.wr(XA, c);
        host.rd(XA, d);
        `CMP("xtal reg", {16'h0, c[15:0]}, d)
        `CMP("xtal out", c[15:0], xtal_buf_cfg_o)
        host.wr(8'h77, c);
        host.rd(8'h77, d);
        `CMP("unmapped", 32'h0, d)
        $display("registers done");
        for (int i = 0; i < 8; i++) begin
            m = (i == 0) ? 4'h1 : (i == 1) ? 4'h0 : 4'($random(seed));
            e = (i < 2) ? 4'h0 : 4'($random(seed));
            host.wr(CA, {24'h0, e, m});
            c = frac_div_o;
            d = c ^ {22'h0, 10'($random(seed)) | 10'h1};
            host.frac(d);
            n = 0;
            do begin
                @(negedge clk_i);
                n++;
            end while (ramp_busy_o === 1'b1 && n < 2000);
            `CMP("ramp cycles", ramp_len(c, d, m, e), n)
            `CMP("ramp end", d, frac_div_o)
        end
        $display("ramp done");
        m = 4'($random(seed)) | 4'h2;
        output_int_div_value_i = {24'($random(seed)), 4'h0, m};
        host.wr(CA, 32'h0001_0000);
        period(n);
        period(n);
        `CMP("int period", int'(m), n)
        $display("integer divide done");
        @(negedge clk_i);
        output_int_div_value_i = $random(seed);
        host.wr(CA, 32'h000F_0F00);
        `CMP("half bits", 4'hF, half_integer_div_sel_o)
        period(n);
        period(n);
        @(posedge out_tick_o[0]);
        p = int'(($realtime - t0) / 5.0) - n;
        `CMP("half pair", 9, n + p)
        $display("half divide done");
        @(negedge clk_i);
        rst_n_i = 1'b0;
        @(negedge clk_i);
        `CMP("reset enables", 4'h0, div_en_o)
        rst_n_i = 1'b1;
        host.rd(CA, d);
        `CMP("ctrl after reset", fdr_pkg::DIV_RAMP_RESET, d)
        `CMP("feedback reset", 32'h0, frac_div_o)
        $display("reset done");
        give_verdict();
    end
endmodule
